// ### core/dma_channel_irq_coalesce_status.v
// Coalescing control, halted/idle status and interrupt for one channel.
//
// Implementation choice: register access over AHB-Lite.
`default_nettype none
`include "dma_coalesce_consts.vh"

// Function
// - Reserved bits 15 and 2 ignore writes, read zero.
// - Threshold counts completions down; zero raises interrupt.
// - Zero threshold write keeps previous value.
// - Direct mode ignores threshold and delay fields.
// - Delay timer starts at packet end, restarts.
// - One delay unit equals 125 clock periods.
// - Zero delay value disables delay interrupt.
// - Status register sits at offset four.
// - Halted resets one; set after stop and drain.
// - Direct mode halted after stop and data drain.
// - Halted may lag the clearing of run/stop.
// - Tail or length writes ignored while run/stop is clear.
// - Scatter-gather idle when tail reached, queue empty.
// - Tail write to idle channel resumes processing.
// - Direct idle after transfer done, zero while busy.
// - Idle zero while halted and, in direct mode, before first transfer.
// - Idle follows descriptors, not bus data beats.
// - Completion interrupt gated by enable bit 12.
// - Delay interrupt gated by enable bit 13.
module dma_channel_irq_coalesce_status #(
   parameter SG_INCLUDED = 1
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire completion_event,
   input wire packet_end,
   input wire packet_start,
   input wire data_busy,
   input wire desc_busy,
   input wire desc_queue_empty,
   input wire xfer_done,
   input wire tail_write,
   input wire length_write,
   output reg run_stop_bit,
   output reg start_op,
   output reg irq
);

   // ---------------------------------------------------------------
   // Bus slave.
   // ---------------------------------------------------------------
   reg wr_pend_ff;
   reg [7:0] addr_ff;
   reg cmpl_en_ff;
   reg dly_en_ff;
   reg [7:0] thresh_ff;
   reg [7:0] dly_ff;
   reg halted_ff;
   reg idle_ff;
   reg started_ff;
   reg [7:0] cnt_ff;
   reg [7:0] unit_cnt_ff;
   reg [7:0] dly_cnt_ff;
   reg dly_run_ff;
   reg cmpl_irq_ff;
   reg dly_irq_ff;
   wire sg_mode;
   wire addr_ok;
   wire ctrl_wr;
   wire [31:0] ctrl_rd;
   wire [31:0] stat_rd;
   wire dly_fire;

   localparam integer UNIT_LAST = `DLY_UNIT_CYCLES - 1;

   assign sg_mode = (SG_INCLUDED != 0);
   assign addr_ok = hsel && hready && htrans == `HTRANS_NONSEQ;
   assign ctrl_wr = wr_pend_ff && addr_ff == `CTRL_ADDR;
   // Reserved bits read zero.
   assign ctrl_rd = {dly_ff, thresh_ff, 1'b0, 1'b0, dly_en_ff, cmpl_en_ff,
      11'h000, run_stop_bit};
   // Status at offset four; idle never shows while halted.
   assign stat_rd = {28'h0000000, sg_mode, 1'b0,
      idle_ff & ~halted_ff, halted_ff};

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_ff <= addr_ok && hwrite;
         if (addr_ok) begin
            addr_ff <= haddr;
         end
         if (addr_ok && !hwrite) begin
            if (haddr == `CTRL_ADDR) begin
               hrdata <= ctrl_rd;
            end else if (haddr == `STAT_ADDR) begin
               hrdata <= stat_rd;
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Control register.
   // ---------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_stop_bit <= 1'b0;
         cmpl_en_ff <= 1'b0;
         dly_en_ff <= 1'b0;
         thresh_ff <= `THRESH_RESET;
         dly_ff <= `DLY_RESET;
      end else if (ctrl_wr) begin
         run_stop_bit <= hwdata[`RUN_STOP_BIT];
         cmpl_en_ff <= hwdata[`CMPL_EN_BIT];
         dly_en_ff <= hwdata[`DLY_EN_BIT];
         if (hwdata[`THRESH_MSB:`THRESH_LSB] != 8'h00) begin
            thresh_ff <= hwdata[`THRESH_MSB:`THRESH_LSB];
         end
         dly_ff <= hwdata[`DLY_MSB:`DLY_LSB];
      end
   end

   // ---------------------------------------------------------------
   // Halted and idle status, only from channel state.
   // ---------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halted_ff <= 1'b1;
         idle_ff <= 1'b0;
         started_ff <= 1'b0;
         start_op <= 1'b0;
      end else begin
         start_op <= 1'b0;
         if (run_stop_bit) begin
            halted_ff <= 1'b0;
         end else if (!data_busy && (!sg_mode || !desc_busy)) begin
            // Halt waits for in-flight work to drain.
            halted_ff <= 1'b1;
         end
         if (sg_mode) begin
            // Idle follows descriptor progress only.
            idle_ff <= run_stop_bit && !desc_busy && desc_queue_empty;
            if (tail_write && run_stop_bit) begin
               start_op <= 1'b1;
               idle_ff <= 1'b0;
            end
         end else begin
            if (length_write && run_stop_bit) begin
               start_op <= 1'b1;
               started_ff <= 1'b1;
               idle_ff <= 1'b0;
            end else if (xfer_done && started_ff) begin
               idle_ff <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Completion threshold counter and delay timer.
   // ---------------------------------------------------------------
   assign dly_fire = dly_run_ff && unit_cnt_ff == UNIT_LAST &&
      dly_cnt_ff == dly_ff - 8'h01;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= `THRESH_RESET;
         unit_cnt_ff <= 8'h00;
         dly_cnt_ff <= 8'h00;
         dly_run_ff <= 1'b0;
         cmpl_irq_ff <= 1'b0;
         dly_irq_ff <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (ctrl_wr && hwdata[`THRESH_MSB:`THRESH_LSB] != 8'h00) begin
            cnt_ff <= hwdata[`THRESH_MSB:`THRESH_LSB];
         end else if (completion_event && sg_mode) begin
            if (cnt_ff == 8'h01) begin
               cnt_ff <= thresh_ff;
               cmpl_irq_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 8'h01;
            end
         end
         if (packet_start || dly_fire || dly_ff == 8'h00 || !sg_mode) begin
            // Stop and clear on new packet or timeout; zero disables.
            dly_run_ff <= 1'b0;
            unit_cnt_ff <= 8'h00;
            dly_cnt_ff <= 8'h00;
         end else if (packet_end) begin
            dly_run_ff <= 1'b1;
            unit_cnt_ff <= 8'h00;
            dly_cnt_ff <= 8'h00;
         end else if (dly_run_ff) begin
            if (unit_cnt_ff == UNIT_LAST) begin
               unit_cnt_ff <= 8'h00;
               dly_cnt_ff <= dly_cnt_ff + 8'h01;
            end else begin
               unit_cnt_ff <= unit_cnt_ff + 8'h01;
            end
         end
         if (dly_fire && sg_mode) begin
            dly_irq_ff <= 1'b1;
         end
         if (!run_stop_bit) begin
            cmpl_irq_ff <= 1'b0;
            dly_irq_ff <= 1'b0;
         end
         irq <= (cmpl_irq_ff && cmpl_en_ff) ||
            (dly_irq_ff && dly_en_ff && sg_mode);
      end
   end

endmodule // dma_channel_irq_coalesce_status
`default_nettype wire

// ### core/dma_coalesce_consts.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef DMA_COALESCE_CONSTS_VH
`define DMA_COALESCE_CONSTS_VH
`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h04
`define RUN_STOP_BIT 0
`define CMPL_EN_BIT 12
`define DLY_EN_BIT 13
`define RSVD_CTRL_BIT 15
`define THRESH_LSB 16
`define THRESH_MSB 23
`define DLY_LSB 24
`define DLY_MSB 31
`define HALTED_BIT 0
`define IDLE_BIT 1
`define RSVD_STAT_BIT 2
`define SG_INCL_BIT 3
`define THRESH_RESET 8'h01
`define DLY_RESET 8'h00
`define DLY_UNIT_CYCLES 125
`define HTRANS_NONSEQ 2'h2
`endif

// ### verification/dma_coalesce_chk.sv
// Checker for the coalescing and status block.
`default_nettype none
module dma_coalesce_chk #(
   parameter SG_INCLUDED = 1
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire tail_write,
   input wire length_write,
   input wire run_stop_bit,
   input wire start_op,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rd_go = hsel && hready && htrans == 2'h2 && !hwrite;
   wire op_wr = (SG_INCLUDED != 0) ? tail_write : length_write;
   sequence stat_rd; rd_go && haddr == 8'h04; endsequence
   sequence ctrl_rd; rd_go && haddr == 8'h00; endsequence
   sequence stopped2; !run_stop_bit [*2]; endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_stat_rsvd: assert property (stat_rd |=> !hrdata[2])
      else $error("status reserved bit set");
   a_idle_masked: assert property (
      stat_rd |=> !(hrdata[0] && hrdata[1]))
      else $error("idle read with halted");
   a_ctrl_rsvd: assert property (ctrl_rd |=> !hrdata[15])
      else $error("control reserved bit set");
   a_thresh_nz: assert property (ctrl_rd |=> hrdata[23:16] != 8'h00)
      else $error("threshold read as zero");
   a_start_cause: assert property (start_op |-> $past(op_wr))
      else $error("start without a pointer write");
   a_halt_nostart: assert property (stopped2 ##0 op_wr |=> !start_op)
      else $error("start while stopped");
   a_irq_clear: assert property (stopped2 |=> !irq)
      else $error("interrupt while stopped");
endmodule // dma_coalesce_chk
bind dma_channel_irq_coalesce_status dma_coalesce_chk
   #(.SG_INCLUDED(SG_INCLUDED)) u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .tail_write,
   .length_write, .run_stop_bit, .start_op, .irq);
`default_nettype wire

// ### verification/dma_channel_irq_coalesce_status_test.sv
// Self-checking bench for the coalescing and status block.
`default_nettype none
module dma_channel_irq_coalesce_status_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic [7:0] haddr = 8'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, r;
   logic completion_event = 1'h0, packet_end = 1'h0, tail_write = 1'h0;
   logic data_busy = 1'h0, desc_busy = 1'h0, desc_queue_empty = 1'h1;
   wire [31:0] hrdata;
   wire hreadyout, hresp, run_stop_bit, start_op, irq;
   int n_mismatch = 0, samples_checked = 0;
   dma_channel_irq_coalesce_status dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .completion_event, .packet_end,
      .packet_start(1'h0), .data_busy, .desc_busy, .desc_queue_empty,
      .xfer_done(1'h0), .tail_write, .length_write(1'h0), .run_stop_bit,
      .start_op, .irq);
   always #2 hclk = ~hclk;
   task chk(input string nm, input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      r = hrdata;
   endtask
   task tail(input logic e);
      logic seen;
      seen = 1'h0;
      tail_write <= 1'h1;
      repeat (3) begin
         @(posedge hclk);
         tail_write <= 1'h0;
         #1 seen |= start_op;
      end
      chk("start_op", {31'h0, seen}, {31'h0, e});
   endtask
   task wrap_up;
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      bus(1'h0, 8'h04, 32'h0);
      chk("status_rst", r & 32'hF, 32'h9);
      bus(1'h0, 8'h00, 32'h0);
      chk("ctrl_rst", r, 32'h0001_0000);
   endtask
   task t_thresh;
      bus(1'h1, 8'h00, 32'h0003_1001);
      bus(1'h1, 8'h00, 32'h0000_9001);
      bus(1'h0, 8'h00, 32'h0);
      chk("ctrl_thr", r, 32'h0003_1001);
      bus(1'h1, 8'h04, 32'h0000_0007);
      bus(1'h0, 8'h04, 32'h0);
      chk("status_run", r & 32'hF, 32'hA);
      chk("run_stop", {31'h0, run_stop_bit}, 32'h1);
      completion_event <= 1'h1;
      repeat (2) @(posedge hclk);
      completion_event <= 1'h0;
      repeat (3) @(posedge hclk);
      chk("irq_two", {31'h0, irq}, 32'h0);
      completion_event <= 1'h1;
      @(posedge hclk);
      completion_event <= 1'h0;
      repeat (2) @(posedge hclk);
      #1 chk("irq_three", {31'h0, irq}, 32'h1);
   endtask
   task t_delay;
      bus(1'h1, 8'h00, 32'h0);
      bus(1'h1, 8'h00, 32'h0101_2001);
      packet_end <= 1'h1;
      @(posedge hclk);
      packet_end <= 1'h0;
      repeat (115) @(posedge hclk);
      #1 chk("irq_early", {31'h0, irq}, 32'h0);
      repeat (20) @(posedge hclk);
      #1 chk("irq_delay", {31'h0, irq}, 32'h1);
   endtask
   task t_halt;
      @(posedge hclk);
      data_busy <= 1'h1;
      desc_busy <= 1'h1;
      bus(1'h1, 8'h00, 32'h0101_2000);
      bus(1'h0, 8'h04, 32'h0);
      chk("halt_busy", r & 32'h1, 32'h0);
      data_busy <= 1'h0;
      desc_busy <= 1'h0;
      repeat (2) @(posedge hclk);
      bus(1'h0, 8'h04, 32'h0);
      chk("halted", r & 32'hF, 32'h9);
      tail(1'h0);
      bus(1'h1, 8'h00, 32'h0101_2001);
      tail(1'h1);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset;
      t_thresh;
      t_delay;
      t_halt;
      wrap_up;
   end
   initial begin
      repeat (2000) @(posedge hclk);
      n_mismatch++;
      wrap_up;
   end
endmodule // dma_channel_irq_coalesce_status_test
`default_nettype wire
